// >>> adc_device_end.sv
`timescale 1ns/1ps
module adc_device_end
  import adc_pins_pkg::*;
#(
  parameter int RES_BITS = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  adc_pins_if.device pins,
  input wire logic [WORD_W-1:0] code_i,
  output logic [NUM_PAIRS-1:0] ranges_o,
  output logic refbuf_en_o,
  output logic [WORD_W-1:0] ctrl_o,
  output logic [NUM_PAIRS-1:0] conv_pairs_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] prev;
    dev_state_t st;
    logic [7:0] cnt;
    logic armed;
    logic busy;
    logic [NUM_PAIRS-1:0] pairs;
    logic [NUM_PAIRS-1:0] ranges;
    logic [WORD_W-1:0] ctrl;
    logic refbuf;
    logic [2:0] rd_ptr;
    logic [WORD_W-1:0] dout;
    logic [WORD_W-1:0] oe;
    logic [5:0][WORD_W-1:0] res;
    logic [NUM_PAIRS-1:0][2*WORD_W-1:0] sh;
  } dev_t;

  dev_t state_reg;
  dev_t state_next;
  logic [PIN_W-1:0] pin_vec;

  // ==========================================================
  // helpers
  // result bits above the variant width read as zero
  function automatic logic [WORD_W-1:0] trim(input logic [WORD_W-1:0] c);
    trim = c & (WORD_MASK >> (WORD_W - RES_BITS));
  endfunction : trim

  // all pins gathered so one synchroniser covers them
  assign pin_vec = {
    pins.db, pins.cs_n, pins.rd_n, pins.wr_n, pins.sample_trigger,
    pins.adc_reset, pins.range_select, pins.hw_sw_sel,
    pins.interface_kind_select, pins.lane_c_select
  };

  // ==========================================================
  // next state
  always_comb begin
    logic [PIN_W-1:0] p;
    logic [PIN_W-1:0] q;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [2:0] picks;
    logic [WORD_W-1:0] db;
    logic sw;
    logic ser;
    logic cs;
    logic go;
    p = state_reg.s2;
    q = state_reg.prev;
    rise = p[PIN_TRIG +: 3] & ~q[PIN_TRIG +: 3];
    fall = ~p[PIN_TRIG +: 3] & q[PIN_TRIG +: 3];
    db = p[PIN_DB +: WORD_W];
    sw = p[PIN_HWSW];
    ser = p[PIN_SER];
    cs = ~p[PIN_CS];
    picks = '0;
    go = 1'b0;
    state_next = state_reg;
    // second stage and its delayed copy prev feed logic; first stage is read by nothing else
    state_next.s1 = pin_vec;
    state_next.s2 = state_reg.s1;
    state_next.prev = state_reg.s2;

    // pin drive: parallel read or serial lanes
    state_next.oe = '0;
    state_next.dout = '0;
    if (!ser && cs && !p[PIN_RD]) begin
      state_next.oe = WORD_MASK;
      state_next.dout = trim(state_reg.res[state_reg.rd_ptr]);
    end else if (ser) begin
      state_next.oe[LANE_A_BIT] = 1'b1;
      state_next.oe[LANE_A_BIT + 1] = 1'b1;
      state_next.oe[LANE_A_BIT + 2] = p[PIN_LANEC];
      for (int k = 0; k < NUM_PAIRS; k++) begin
        state_next.dout[LANE_A_BIT + k] = state_reg.sh[k][2*WORD_W-1];
      end
    end

    // serial frame: load at select fall, shift at clock fall
    if (ser && cs && q[PIN_CS]) begin
      for (int k = 0; k < NUM_PAIRS; k++) begin
        state_next.sh[k] = {trim(state_reg.res[2*k]), trim(state_reg.res[2*k+1])};
      end
    end else if (ser && cs && !db[SCLK_BIT] && q[PIN_DB + SCLK_BIT]) begin
      for (int k = 0; k < NUM_PAIRS; k++) begin
        state_next.sh[k] = {state_reg.sh[k][2*WORD_W-2:0], 1'b0};
      end
    end

    // reference buffer follows bit fourteen only in serial mode
    if (ser) begin
      state_next.refbuf = db[BIT_FOURTEEN];
    end

    // parallel read end steps to the next channel
    if (!ser && cs && p[PIN_RD] && !q[PIN_RD]) begin
      if (state_reg.rd_ptr == LAST_CH) begin
        state_next.rd_ptr = '0;
      end else begin
        state_next.rd_ptr = state_reg.rd_ptr + 3'h1;
      end
    end

    // data is taken as write rises, while the host still drives it
    if (!ser && cs && p[PIN_WR] && !q[PIN_WR]) begin
      state_next.ctrl = db;
    end

    // software mode ignores the range pin
    if (sw) begin
      state_next.ranges = state_reg.ctrl[CR_RNG_LSB +: NUM_PAIRS];
    end

    // a falling trigger arms the next rising one
    if (|fall) begin
      state_next.armed = 1'b1;
    end

    // conversion sequencer
    case (state_reg.st)
      D_IDLE: begin
        if (sw) begin
          go = rise[0] & state_reg.armed;
          picks = state_reg.ctrl[CR_PAIR_LSB +: NUM_PAIRS];
        end else begin
          go = (|rise) & state_reg.armed;
          picks = rise;
        end
        if (go && (|picks)) begin
          state_next.st = D_CONV;
          state_next.cnt = 8'(CONV_CYCLES - 1);
          state_next.busy = 1'b1;
          state_next.pairs = picks;
          state_next.armed = 1'b0;
        end
      end
      D_CONV: begin
        if (state_reg.cnt == 8'h00) begin
          state_next.st = D_IDLE;
          state_next.busy = 1'b0;
          state_next.rd_ptr = '0;
          for (int k = 0; k < NUM_PAIRS; k++) begin
            if (state_reg.pairs[k]) begin
              state_next.res[2*k] = code_i;
              state_next.res[2*k+1] = code_i;
            end
          end
          // range for the next conversion is caught as busy falls
          if (!sw) begin
            state_next.ranges = {NUM_PAIRS{p[PIN_RANGE]}};
          end
        end else begin
          state_next.cnt = state_reg.cnt - 8'h01;
        end
      end
      default: begin
        state_next.st = D_IDLE;
      end
    endcase

    // reset pin overrides the sequencer; trigger level decides arming
    if (p[PIN_RST]) begin
      state_next.st = D_IDLE;
      state_next.busy = 1'b0;
      state_next.armed = p[PIN_TRIG];
      if (sw) begin
        state_next.ctrl = '0;
      end else begin
        state_next.ranges = {NUM_PAIRS{p[PIN_RANGE]}};
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  assign pins.dev_db_out = state_reg.dout;
  assign pins.dev_db_oe = state_reg.oe;
  assign pins.busy = state_reg.busy;
  assign ranges_o = state_reg.ranges;
  assign refbuf_en_o = state_reg.refbuf;
  assign ctrl_o = state_reg.ctrl;
  assign conv_pairs_o = state_reg.pairs;

endmodule : adc_device_end

// >>> adc_host_end.sv
`timescale 1ns/1ps
module adc_host_end
  import adc_pins_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  adc_pins_if.host pins,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [WORD_W:0] s1;
    logic [WORD_W:0] s2;
    host_state_t st;
    logic [7:0] cnt;
    logic [5:0] bits;
    logic [7:0] cfg;
    logic [WORD_W-1:0] rdata;
    logic [NUM_PAIRS-1:0][31:0] lanes;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic rstp;
    logic [2:0] trig;
    logic sclk;
    logic [WORD_W-1:0] dout;
    logic [WORD_W-1:0] doe;
    logic ack;
    logic [31:0] dat;
  } host_t;

  host_t state_reg;
  host_t state_next;

  // ==========================================================
  // next state
  always_comb begin
    logic done;
    logic take;
    logic ser;
    ser = state_reg.cfg[CFG_SER];
    done = (state_reg.cnt == 8'h00);
    take = wb_cyc_i & wb_stb_i & state_reg.ack & wb_we_i;
    state_next = state_reg;
    state_next.s1 = {pins.busy, pins.db};
    state_next.s2 = state_reg.s1;
    if (!done) begin
      state_next.cnt = state_reg.cnt - 8'h01;
    end

    // one wait state, ack dropped the cycle after it was given
    state_next.ack = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    state_next.dat = '0;
    case (wb_adr_i)
      REG_CONFIG: state_next.dat = {24'h000000, state_reg.cfg};
      REG_STATUS: state_next.dat = {state_reg.rdata, 14'h0000,
                                    state_reg.s2[WORD_W], state_reg.st != H_IDLE};
      REG_LANE_A: state_next.dat = state_reg.lanes[0];
      REG_LANE_B: state_next.dat = state_reg.lanes[1];
      REG_LANE_C: state_next.dat = state_reg.lanes[2];
      default: state_next.dat = '0;
    endcase

    // writes land on the edge where the master sees ack
    if (take && wb_adr_i == REG_CONFIG && wb_sel_i[0]) begin
      state_next.cfg = wb_dat_i[7:0];
    end

    case (state_reg.st)
      H_IDLE: begin
        if (take && wb_adr_i == REG_COMMAND && (|wb_sel_i)) begin
          if (wb_dat_i[CMD_RESET]) begin
            state_next.st = H_RESET;
            state_next.rstp = 1'b1;
            state_next.cnt = 8'(RESET_CYCLES - 1);
          end else if (wb_dat_i[CMD_TRIG]) begin
            state_next.st = H_TRIG_LOW;
            state_next.cnt = 8'(TRIG_LOW_CYCLES - 1);
            if (state_reg.cfg[CFG_HWSW] || ser) begin
              state_next.trig = TRIG_A_ONLY;
            end else begin
              state_next.trig = ~state_reg.cfg[CFG_PAIRS +: NUM_PAIRS];
            end
          end else if (wb_dat_i[CMD_READ] && !ser) begin
            state_next.st = H_STROBE;
            state_next.cs_n = 1'b0;
            state_next.rd_n = 1'b0;
            state_next.cnt = 8'(STROBE_CYCLES - 1);
          end else if (wb_dat_i[CMD_WRITE] && !ser) begin
            state_next.st = H_STROBE;
            state_next.cs_n = 1'b0;
            state_next.wr_n = 1'b0;
            state_next.doe = WORD_MASK;
            state_next.dout = wb_dat_i[CMD_DATA +: WORD_W];
            state_next.cnt = 8'(STROBE_CYCLES - 1);
          end else if (wb_dat_i[CMD_SREAD] && ser) begin
            state_next.st = H_SHIFT_LO;
            state_next.cs_n = 1'b0;
            state_next.bits = '0;
            state_next.cnt = 8'(SCLK_HALF - 1);
          end
        end
      end
      H_RESET: begin
        if (done) begin
          state_next.rstp = 1'b0;
          state_next.st = H_GAP;
          state_next.cnt = 8'(STROBE_CYCLES - 1);
        end
      end
      H_TRIG_LOW: begin
        if (done) begin
          state_next.trig = '1;
          state_next.st = H_GAP;
          state_next.cnt = 8'(STROBE_CYCLES - 1);
        end
      end
      H_STROBE: begin
        if (done) begin
          if (!state_reg.rd_n) begin
            state_next.rdata = state_reg.s2[WORD_W-1:0];
          end
          state_next.rd_n = 1'b1;
          state_next.wr_n = 1'b1;
          state_next.st = H_GAP;
          state_next.cnt = 8'(STROBE_CYCLES - 1);
        end
      end
      H_SHIFT_LO: begin
        if (done && state_reg.bits == 6'(SREAD_BITS)) begin
          state_next.st = H_GAP;
          state_next.cnt = 8'(SCLK_HALF - 1);
        end else if (done) begin
          state_next.sclk = 1'b1;
          state_next.st = H_SHIFT_HI;
          state_next.cnt = 8'(SCLK_HALF - 1);
        end
      end
      H_SHIFT_HI: begin
        if (done) begin
          for (int k = 0; k < NUM_PAIRS; k++) begin
            state_next.lanes[k] = {state_reg.lanes[k][30:0], state_reg.s2[LANE_A_BIT + k]};
          end
          state_next.sclk = 1'b0;
          state_next.bits = state_reg.bits + 6'h01;
          state_next.st = H_SHIFT_LO;
          state_next.cnt = 8'(SCLK_HALF - 1);
        end
      end
      H_GAP: begin
        // select and write data outlast the strobe so the device sees both
        if (done) begin
          state_next.cs_n = 1'b1;
          state_next.doe = '0;
          state_next.st = H_IDLE;
        end
      end
      default: begin
        state_next.st = H_IDLE;
      end
    endcase

    // serial mode: ground spare bits, drive clock and buffer enable
    if (ser) begin
      state_next.doe = SER_DRIVE_MASK;
      state_next.dout = '0;
      state_next.dout[BIT_FOURTEEN] = state_reg.cfg[CFG_REFBUF];
      state_next.dout[SCLK_BIT] = state_next.sclk;
    end
  end

  // ==========================================================
  // registers; strobes and trigger idle high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.cs_n <= 1'b1;
      state_reg.rd_n <= 1'b1;
      state_reg.wr_n <= 1'b1;
      state_reg.trig <= 3'h7;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pins.host_db_out = state_reg.dout;
  assign pins.host_db_oe = state_reg.doe;
  assign pins.cs_n = state_reg.cs_n;
  assign pins.rd_n = state_reg.rd_n;
  assign pins.wr_n = state_reg.wr_n;
  assign pins.adc_reset = state_reg.rstp;
  assign pins.sample_trigger = state_reg.trig;
  assign pins.range_select = state_reg.cfg[CFG_RANGE];
  assign pins.hw_sw_sel = state_reg.cfg[CFG_HWSW];
  assign pins.interface_kind_select = state_reg.cfg[CFG_SER];
  assign pins.lane_c_select = state_reg.cfg[CFG_LANEC];
  assign wb_dat_o = state_reg.dat;
  assign wb_ack_o = state_reg.ack;

endmodule : adc_host_end

// >>> adc_host_pin_reset_range_ctrl_chk.sv
`timescale 1ns/1ps
// ==========================================================
// pin-level checks on the link between host end and device end
module adc_host_pin_reset_range_ctrl_chk
  import adc_pins_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] dev_db_oe,
  input wire logic [15:0] db,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic adc_reset,
  input wire logic hw_sw_sel,
  input wire logic interface_kind_select,
  input wire logic lane_c_select,
  input wire logic busy,
  input wire logic [2:0] sample_trigger
);
  logic [2:0] trig_reg;
  logic [4:0] hist_reg;
  logic [7:0] bcnt_reg;
  logic abort_reg;
  logic trig_rise;

  // any trigger pin going high; the pins idle high, so reset state is all ones
  assign trig_rise = |(sample_trigger & ~trig_reg);

  // helper history: trigger rises, busy length, and resets seen while busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_reg <= 3'h7;
      hist_reg <= 5'h00;
      bcnt_reg <= 8'h00;
      abort_reg <= 1'b0;
    end else begin
      trig_reg <= sample_trigger;
      hist_reg <= {hist_reg[3:0], trig_rise};
      bcnt_reg <= busy ? bcnt_reg + 8'h01 : 8'h00;
      abort_reg <= busy ? (abort_reg | adc_reset) : 1'b0; // aborted runs are short
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // sequences
  // five cycles give the two-flop synchroniser and the output stage time to settle
  sequence s_par_read;
    (!interface_kind_select && !cs_n && !rd_n) [*5];
  endsequence
  sequence s_par_idle;
    (!interface_kind_select && (cs_n || rd_n)) [*5];
  endsequence
  sequence s_sw_reset;
    $rose(adc_reset) && hw_sw_sel;
  endsequence

  // ==========================================================
  // assertions
  a_par_lane_c: assert property (s_par_read |-> dev_db_oe[10])
    else $error("parallel read leaves lane c pin undriven");
  a_par_bus_free: assert property (s_par_idle |-> dev_db_oe == 16'h0000)
    else $error("device drives data bus outside a read");
  a_ser_lane_on: assert property (
    (interface_kind_select && lane_c_select && !cs_n) [*5] |-> dev_db_oe[10])
    else $error("serial lane c not driven while selected");
  a_ser_lane_off: assert property (
    (interface_kind_select && !lane_c_select) [*5] |-> !dev_db_oe[10])
    else $error("serial lane c driven while deselected");
  a_ser_host_pins: assert property (interface_kind_select [*5] |->
    !dev_db_oe[14] && !dev_db_oe[11] && !dev_db_oe[6] && db[11] == 1'b0)
    else $error("serial mode pin ownership broken");
  a_busy_length: assert property (
    $fell(busy) && !abort_reg |-> bcnt_reg == 8'(CONV_CYCLES))
    else $error("busy length differs from conversion time");
  a_busy_cause: assert property ($rose(busy) |-> |hist_reg[4:2])
    else $error("busy rose without a trigger rise");
  a_reset_abort: assert property (s_sw_reset |-> ##4 (!busy) [*3])
    else $error("reset did not abort conversion");
  // one clock of 100 ns covers the nominal width; a longer pulse means a miscounted timer
  a_reset_width: assert property ($rose(adc_reset) |=> !adc_reset)
    else $error("reset pulse not one clock wide");
  // hardware mode may only be reset between conversions
  a_reset_idle: assert property ($rose(adc_reset) && !hw_sw_sel |-> !busy)
    else $error("hardware mode reset issued during a conversion");
endmodule : adc_host_pin_reset_range_ctrl_chk

// >>> adc_host_pin_reset_range_ctrl_tb.sv
`timescale 1ns/1ps
module adc_host_pin_reset_range_ctrl_tb import adc_pins_pkg::*;;
  typedef struct {logic [31:0] val; logic [31:0] mask;} note_t;
  localparam int RES [3] = '{16, 14, 12};
  localparam logic [15:0] RM [3] = '{16'hFFFF, 16'h3FFF, 16'h0FFF};
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we;
  logic [4:0] wb_adr;
  logic [31:0] wb_dat, r;
  logic [15:0] code, code_v, cv;
  logic [31:0] rdat [3];
  logic ack [3], refbuf [3];
  logic [2:0] ranges [3], pairs [3];
  logic [15:0] ctrl [3];
  note_t q[$];
  note_t nt;
  int n_fail, checks_done, cyc_n;
  int seed = 32'hB59FC2E6;

  adc_pins_if pins [3] ();

  // ==========================================================
  // three pairs, one per resolution, sharing the bus and the input code
  for (genvar i = 0; i < 3; i++) begin : g_end
    adc_host_end u_adc_host_end (.clk_i(clk_i), .rst_i(rst_i), .pins(pins[i]),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(rdat[i]), .wb_ack_o(ack[i]));
    adc_device_end #(.RES_BITS(RES[i])) u_adc_device_end (.clk_i(clk_i), .rst_i(rst_i),
      .pins(pins[i]), .code_i(code), .ranges_o(ranges[i]), .refbuf_en_o(refbuf[i]),
      .ctrl_o(ctrl[i]), .conv_pairs_o(pairs[i]));
  end

  adc_host_pin_reset_range_ctrl_chk u_adc_host_pin_reset_range_ctrl_chk (.clk_i(clk_i),
    .rst_i(rst_i), .dev_db_oe(pins[0].dev_db_oe), .db(pins[0].db), .cs_n(pins[0].cs_n),
    .rd_n(pins[0].rd_n), .adc_reset(pins[0].adc_reset), .hw_sw_sel(pins[0].hw_sw_sel),
    .interface_kind_select(pins[0].interface_kind_select),
    .lane_c_select(pins[0].lane_c_select), .busy(pins[0].busy),
    .sample_trigger(pins[0].sample_trigger));

  // ==========================================================
  // clock and hang guard
  always #50 clk_i = ~clk_i;

  // the ceiling is over ten times the expected run; a hang counts as a mismatch
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ==========================================================
  // compare tasks and closing
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp32

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // read monitor: the oldest note is matched to each read answer, per resolution
  always @(posedge clk_i) begin
    if (ack[0] === 1'b1 && wb_we === 1'b0 && q.size() > 0) begin
      nt = q.pop_front();
      for (int i = 0; i < 3; i++) begin
        if (nt.mask != 32'h0) cmp32(rdat[i] & nt.mask, nt.val & {RM[i], RM[i]} & nt.mask);
      end
    end
  end

  // ==========================================================
  // bus tasks: single classic cycle, held until ack is seen
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    int n;
    if (!we) q.push_back('{d, m});
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack[0] !== 1'b1 && n < 50);
    if (n == 50) n_fail++;
    r = rdat[0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // issue a command, then poll status until the chosen busy bits clear
  task automatic run(input logic [31:0] cmd, input logic [1:0] wm);
    int k;
    wb(1'b1, REG_COMMAND, cmd, 32'h0);
    k = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0, 32'h0);
      k++;
    end while ((r[1:0] & wm) !== 2'b00 && k < 300);
    if (k == 300) n_fail++;
  endtask : run

  // ==========================================================
  // main sequence
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, code} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, REG_CONFIG, 32'h0, 32'hFFFFFFFF);
    wb(1'b0, REG_STATUS, 32'h0, 32'hFFFFFFFF);
    wb(1'b1, 5'h1C, 32'h5A, 32'h0);
    wb(1'b0, 5'h1C, 32'h0, 32'hFFFFFFFF);
    $display("reset and map test done");
    // hardware mode: reset takes the range pin, busy fall takes it again
    wb(1'b1, REG_CONFIG, 32'hF0, 32'h0);
    run(32'h1, 2'b11);
    chk({13'h0, ranges[0]}, 16'h0007);
    // random pair mask, pair a kept so channel 0 holds the new result
    cv = 16'($random(seed));
    cv[5] = 1'b1;
    wb(1'b1, REG_CONFIG, {24'h000000, cv[7:5], 5'h00}, 32'h0);
    code_v = 16'($random(seed));
    code_v[15:12] = 4'hF;
    code <= code_v;
    run(32'h2, 2'b11);
    chk({13'h0, ranges[0]}, 16'h0000);
    chk({13'h0, pairs[0]}, {13'h0, cv[7:5]});
    run(32'h4, 2'b01);
    wb(1'b0, REG_STATUS, {code_v, 16'h0}, 32'hFFFF0000);
    $display("hardware mode test done");
    // software mode: range pin high but ignored, ranges from control bits
    wb(1'b1, REG_CONFIG, 32'h12, 32'h0);
    cv = 16'($random(seed));
    cv[13] = 1'b1;
    cv[10] = 1'b0;
    run({cv, 16'h0008}, 2'b01);
    chk(ctrl[0], cv);
    code_v = 16'($random(seed));
    code <= code_v;
    run(32'h2, 2'b11);
    chk({13'h0, ranges[0]}, {13'h0, cv[12:10]});
    chk({13'h0, pairs[0]}, {13'h0, cv[15:13]});
    run(32'h2, 2'b01);
    run(32'h1, 2'b11);
    chk(ctrl[0], 16'h0000);
    run(32'hE0000008, 2'b01);
    chk(ctrl[0], 16'hE000);
    $display("software mode test done");
    // serial mode: lane c on then off, reference buffer follows bit fourteen
    wb(1'b1, REG_CONFIG, 32'h0F, 32'h0);
    repeat (10) @(posedge clk_i);
    chk({15'h0, refbuf[0]}, 16'h0001);
    code_v = 16'($random(seed));
    code <= code_v;
    run(32'h2, 2'b11);
    run(32'h10, 2'b01);
    wb(1'b0, REG_LANE_A, {code_v, code_v}, 32'hFFFFFFFF);
    wb(1'b0, REG_LANE_C, {code_v, code_v}, 32'hFFFFFFFF);
    wb(1'b1, REG_CONFIG, 32'h03, 32'h0);
    repeat (10) @(posedge clk_i);
    chk({15'h0, refbuf[0]}, 16'h0000);
    run(32'h10, 2'b01);
    wb(1'b0, REG_LANE_B, {code_v, code_v}, 32'hFFFFFFFF);
    wb(1'b0, REG_LANE_C, 32'h0, 32'hFFFFFFFF);
    $display("serial mode test done");
    repeat (3) @(posedge clk_i);
    summarize();
  end
endmodule : adc_host_pin_reset_range_ctrl_tb

// >>> adc_pins_if.sv
`timescale 1ns/1ps
// shared converter pins; each data bit is a wired level built from both enables
interface adc_pins_if;
  logic [15:0] host_db_out;
  logic [15:0] host_db_oe;
  logic [15:0] dev_db_out;
  logic [15:0] dev_db_oe;
  logic [15:0] db;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic adc_reset;
  logic range_select;
  logic hw_sw_sel;
  logic interface_kind_select;
  logic lane_c_select;
  logic busy;
  logic [2:0] sample_trigger;

  // undriven bits settle low, as a pull-down would make them
  assign db = (host_db_out & host_db_oe) | (dev_db_out & dev_db_oe);

  modport device (
    input db, cs_n, rd_n, wr_n, adc_reset, range_select, hw_sw_sel,
    input interface_kind_select, lane_c_select, sample_trigger,
    output dev_db_out, dev_db_oe, busy
  );
  modport host (
    input db, busy,
    output host_db_out, host_db_oe, cs_n, rd_n, wr_n, adc_reset,
    output range_select, hw_sw_sel, interface_kind_select, lane_c_select,
    output sample_trigger
  );
endinterface : adc_pins_if

// >>> adc_pins_pkg.sv
// Operation
// - serial, lane C select: drive third lane
// - parallel: lane C pin is data output
// - serial: host holds bit eleven low
// - select and read low: device drives result
// - select and write low: load control register
// - narrow variants output leading zeros
// - serial: bit fourteen sets reference buffer
// - reset: software mode aborts, clears control
// - reset: hardware mode takes select pin levels
// - host pulses reset after power-up
// - trigger low in reset: full pulse needed
// - host reset only between conversions; the testbench also resets mid-conversion in software mode, which aborts it
// - hardware mode: range taken at busy fall
// - software mode: ranges from control bits
// - pair choice from pins or control register
package adc_pins_pkg;
  // ==========================================================
  // widths and timing
  localparam int WORD_W = 16;
  localparam int NUM_PAIRS = 3;
  localparam logic [WORD_W-1:0] WORD_MASK = 16'hFFFF;
  localparam int CLK_NS = 100;
  localparam int RESET_PULSE_NS = 100;
  localparam int RESET_CYCLES = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_NS;
  localparam int STROBE_CYCLES = 8;
  localparam int SCLK_HALF = 8;
  localparam int TRIG_LOW_CYCLES = 8;
  localparam int SREAD_BITS = 32;
  // ==========================================================
  // data pin roles
  localparam int SCLK_BIT = 6;
  localparam int LANE_A_BIT = 8;
  localparam int BIT_FOURTEEN = 14;
  localparam logic [WORD_W-1:0] SER_DRIVE_MASK = 16'hF840;
  localparam logic [2:0] LAST_CH = 3'h5;
  // control register: pair select [15:13], pair ranges [12:10]
  localparam int CR_PAIR_LSB = 13;
  localparam int CR_RNG_LSB = 10;
  // ==========================================================
  // device pin vector as seen after the synchroniser
  localparam int PIN_LANEC = 0;
  localparam int PIN_SER = 1;
  localparam int PIN_HWSW = 2;
  localparam int PIN_RANGE = 3;
  localparam int PIN_RST = 4;
  localparam int PIN_TRIG = 5;
  localparam int PIN_WR = 8;
  localparam int PIN_RD = 9;
  localparam int PIN_CS = 10;
  localparam int PIN_DB = 11;
  localparam int PIN_W = 27;
  // ==========================================================
  // host wishbone map and fields
  localparam logic [4:0] REG_CONFIG = 5'h00;
  localparam logic [4:0] REG_COMMAND = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_LANE_A = 5'h0C;
  localparam logic [4:0] REG_LANE_B = 5'h10;
  localparam logic [4:0] REG_LANE_C = 5'h14;
  localparam int CFG_SER = 0;
  localparam int CFG_HWSW = 1;
  localparam int CFG_LANEC = 2;
  localparam int CFG_REFBUF = 3;
  localparam int CFG_RANGE = 4;
  localparam int CFG_PAIRS = 5;
  localparam int CMD_RESET = 0;
  localparam int CMD_TRIG = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_WRITE = 3;
  localparam int CMD_SREAD = 4;
  localparam int CMD_DATA = 16;
  localparam logic [2:0] TRIG_A_ONLY = 3'h6;
  // ==========================================================
  typedef enum logic [0:0] {D_IDLE, D_CONV} dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE, H_RESET, H_TRIG_LOW, H_STROBE, H_SHIFT_LO, H_SHIFT_HI, H_GAP
  } host_state_t;
endpackage : adc_pins_pkg
